// ---- hw/scc_accum.sv ----
// One high-speed accumulation: counts set detector samples over a window.
// Assumes start_in pulses only while idle; len_in held during the window.
module scc_accum
#(
	parameter int LEN_W = 9
)
(
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             reset_in,
	// Control
	input  wire logic             start_in,
	input  wire logic [LEN_W-1:0] len_in,
	input  wire logic             sample_in,
	// Result
	output logic                  busy_out,
	output logic                  done_out,
	output logic [LEN_W-1:0]      ones_out
);
	import scc_pkg::*;

	logic [LEN_W-1:0] left_q;
	logic [LEN_W-1:0] left_d;
	logic [LEN_W-1:0] ones_q;
	logic [LEN_W-1:0] ones_d;
	logic             busy_q;
	logic             busy_d;
	logic             done_q;
	logic             done_d;

	always_comb
	begin
		left_d = left_q;
		ones_d = ones_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (start_in && !busy_q)
		begin
			left_d = len_in;
			ones_d = '0;
			busy_d = 1'b1;
		end
		else if (busy_q)
		begin
			ones_d = ones_q + LEN_W'(sample_in);
			left_d = left_q - LEN_W'(1);
			if (left_q == LEN_W'(1))
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			left_q <= '0;
			ones_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			left_q <= left_d;
			ones_q <= ones_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy_out = busy_q;
	assign done_out = done_q;
	assign ones_out = ones_q;

endmodule

// ---- hw/scc_top.sv ----
// SYSREF calibration control with configuration, status and interrupt registers.
// Assumes an AXI4-Lite master, a synchronous SYSREF and a 1-bit phase detector.
//
// Contract
// - Config bits 3-2 choose 4, 16, 64 or 256 averaged measurements.
// - More averages take longer and give a less noisy delay result.
// - Config bits 1-0 set the accumulation length; a too-long SYSREF period fails.
// - Duration codes 0..3 accumulate 4/16/64/256 cycles and allow periods up to 85/1100/5200/21580.
// - A 0-to-1 change of the trigger bit starts calibration; config is written first.
// - Done reads 1 only while enabled and finished; the 17-bit result counts only then.
module scc_top
(
	// Clock and reset
	input  wire logic                            mclk_in,
	input  wire logic                            reset_in,
	// AXI4-Lite write
	input  wire logic [scc_pkg::ADDR_W-1:0]      s_axi_awaddr_in,
	input  wire logic                            s_axi_awvalid_in,
	output logic                                 s_axi_awready_out,
	input  wire logic [31:0]                     s_axi_wdata_in,
	input  wire logic [3:0]                      s_axi_wstrb_in,
	input  wire logic                            s_axi_wvalid_in,
	output logic                                 s_axi_wready_out,
	output logic [1:0]                           s_axi_bresp_out,
	output logic                                 s_axi_bvalid_out,
	input  wire logic                            s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [scc_pkg::ADDR_W-1:0]      s_axi_araddr_in,
	input  wire logic                            s_axi_arvalid_in,
	output logic                                 s_axi_arready_out,
	output logic [31:0]                          s_axi_rdata_out,
	output logic [1:0]                           s_axi_rresp_out,
	output logic                                 s_axi_rvalid_out,
	input  wire logic                            s_axi_rready_in,
	// Timing reference side
	input  wire logic                            sysref_in,
	input  wire logic                            sysref_sample_in,
	// Status to the rest of the unit
	output logic                                 cal_done_flag_out,
	output logic [scc_pkg::RESULT_W-1:0]         computed_delay_result_out,
	output logic                                 cal_busy_out,
	output logic                                 irq_out
);
	import scc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic                aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [9:0]          aw_idx_q, aw_idx_d;
	logic [31:0]         wdata_q, wdata_d;
	logic                wstrb0_q, wstrb0_d;
	logic                bvalid_q, bvalid_d;
	logic [1:0]          bresp_q, bresp_d;
	logic                rvalid_q, rvalid_d;
	logic [1:0]          rresp_q, rresp_d;
	logic [31:0]         rdata_q, rdata_d;
	logic                trig_q, trig_d;
	logic [7:0]          cfg_q, cfg_d;
	logic [IRQ_W-1:0]    irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
	scc_state_t          state_q, state_d;
	logic [1:0]          avg_code_q, avg_code_d, dur_code_q, dur_code_d;
	logic [8:0]          avg_left_q, avg_left_d;
	logic [SUM_W-1:0]    sum_q, sum_d;
	logic [RESULT_W-1:0] result_q, result_d;
	logic [PER_W-1:0]    per_q, per_d;
	logic                sysref_prev_q;
	logic                fail_q, fail_d;

	logic                wr_go, rise, start, acc_start, acc_done, acc_busy;
	logic [8:0]          acc_ones;
	logic [IRQ_W-1:0]    ev;
	logic [33:0]         scaled;
	logic [4:0]          shift;

	function automatic logic mapped(input logic [9:0] idx);
		mapped = (idx == IDX_CAL_ENABLE) || (idx == IDX_SYSREF_CAL_CFG) ||
			(idx == IDX_CAL_STATUS) || (idx == IDX_CAL_LIVE) ||
			(idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_ENABLE) ||
			(idx == IDX_IRQ_CLEAR);
	endfunction

	// ------------------------------------------------------------
	// Bus channels and registers
	// ------------------------------------------------------------
	assign s_axi_awready_out = !aw_full_q && !bvalid_q;
	assign s_axi_wready_out  = !w_full_q && !bvalid_q;
	assign s_axi_arready_out = !rvalid_q;
	assign wr_go             = aw_full_q && w_full_q && !bvalid_q;

	always_comb
	begin
		aw_full_d  = aw_full_q;
		aw_idx_d   = aw_idx_q;
		w_full_d   = w_full_q;
		wdata_d    = wdata_q;
		wstrb0_d   = wstrb0_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		rvalid_d   = rvalid_q;
		rresp_d    = rresp_q;
		rdata_d    = rdata_q;
		trig_d     = trig_q;
		cfg_d      = cfg_q;
		irq_en_d   = irq_en_q;
		irq_stat_d = irq_stat_q;
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			aw_full_d = 1'b1;
			aw_idx_d  = s_axi_awaddr_in[ADDR_W-1:2];
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			w_full_d = 1'b1;
			wdata_d  = s_axi_wdata_in;
			wstrb0_d = s_axi_wstrb_in[0];
		end
		if (wr_go)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
			if (wstrb0_q)
			begin
				case (aw_idx_q)
					IDX_CAL_ENABLE:     trig_d     = wdata_q[0];
					IDX_SYSREF_CAL_CFG: cfg_d      = wdata_q[7:0];
					IDX_IRQ_ENABLE:     irq_en_d   = wdata_q[IRQ_W-1:0];
					IDX_IRQ_CLEAR:      irq_stat_d = irq_stat_q & ~wdata_q[IRQ_W-1:0];
					default:            ;
				endcase
			end
		end
		else if (bvalid_q && s_axi_bready_in)
			bvalid_d = 1'b0;
		// Hardware set wins over a same-cycle clear
		irq_stat_d = irq_stat_d | ev;
		if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			rvalid_d = 1'b1;
			rresp_d  = mapped(s_axi_araddr_in[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr_in[ADDR_W-1:2])
				IDX_CAL_ENABLE:     rdata_d = {31'h0, trig_q};
				IDX_SYSREF_CAL_CFG: rdata_d = {24'h0, cfg_q};
				IDX_CAL_STATUS:     rdata_d = {14'h0, cal_done_flag_out,
					computed_delay_result_out};
				IDX_CAL_LIVE:       rdata_d = {30'h0, fail_q, cal_busy_out};
				IDX_IRQ_STATUS:     rdata_d = {30'h0, irq_stat_q};
				IDX_IRQ_ENABLE:     rdata_d = {30'h0, irq_en_q};
				default:            rdata_d = 32'h0;
			endcase
		end
		else if (rvalid_q && s_axi_rready_in)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			aw_full_q  <= 1'b0;
			aw_idx_q   <= '0;
			w_full_q   <= 1'b0;
			wdata_q    <= '0;
			wstrb0_q   <= 1'b0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= RESP_OKAY;
			rdata_q    <= '0;
			trig_q     <= 1'b0;
			cfg_q      <= CFG_RESET;
			irq_en_q   <= '0;
			irq_stat_q <= '0;
		end
		else
		begin
			aw_full_q  <= aw_full_d;
			aw_idx_q   <= aw_idx_d;
			w_full_q   <= w_full_d;
			wdata_q    <= wdata_d;
			wstrb0_q   <= wstrb0_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			trig_q     <= trig_d;
			cfg_q      <= cfg_d;
			irq_en_q   <= irq_en_d;
			irq_stat_q <= irq_stat_d;
		end
	end

	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out  = bresp_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out  = rresp_q;
	assign s_axi_rdata_out  = rdata_q;

	// ------------------------------------------------------------
	// Calibration sequencer
	// ------------------------------------------------------------
	assign rise  = sysref_in && !sysref_prev_q;
	assign start = trig_d && !trig_q;
	assign ev    = {(state_q != ST_FAIL) && (state_d == ST_FAIL),
		(state_q != ST_DONE) && (state_d == ST_DONE)};
	function automatic logic [16:0] acc_ones_sum(input logic [SUM_W-1:0] s);
		acc_ones_sum = s;
	endfunction

	assign shift = 5'(4 + 2 * (avg_code_q + dur_code_q));
	// Sum includes the window that finishes in this cycle
	assign scaled = {acc_ones_sum(sum_q + SUM_W'(acc_ones)), 17'h0} >> shift;

	always_comb
	begin
		state_d    = state_q;
		avg_code_d = avg_code_q;
		dur_code_d = dur_code_q;
		avg_left_d = avg_left_q;
		sum_d      = sum_q;
		result_d   = result_q;
		per_d      = (per_q == '1) ? per_q : per_q + PER_W'(1);
		fail_d     = fail_q;
		acc_start  = 1'b0;
		if (rise)
			per_d = PER_W'(1);
		case (state_q)
			ST_IDLE, ST_DONE, ST_FAIL:
			begin
				if (start)
				begin
					state_d    = ST_WAIT;
					avg_code_d = cfg_q[CFG_AVG_LSB +: 2];
					dur_code_d = cfg_q[CFG_DUR_LSB +: 2];
					avg_left_d = scc_count_of(cfg_q[CFG_AVG_LSB +: 2]);
					sum_d      = '0;
					per_d      = PER_W'(1);
					fail_d     = 1'b0;
				end
			end
			ST_WAIT:
			begin
				if (rise)
				begin
					state_d   = ST_ACC;
					acc_start = 1'b1;
				end
			end
			ST_ACC:
			begin
				if (acc_done)
				begin
					sum_d      = sum_q + SUM_W'(acc_ones);
					avg_left_d = avg_left_q - 9'd1;
					state_d    = (avg_left_q == 9'd1) ? ST_DONE : ST_WAIT;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (state_d == ST_DONE && state_q != ST_DONE)
			result_d = (scaled > 34'h1ffff) ? 17'h1ffff : scaled[RESULT_W-1:0];
		// Period longer than the duration code allows
		if ((state_q == ST_WAIT || state_q == ST_ACC) &&
			per_q > scc_max_period(dur_code_q))
		begin
			state_d = ST_FAIL;
			fail_d  = 1'b1;
		end
		if (!trig_q && !start)
			state_d = ST_IDLE;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			state_q       <= ST_IDLE;
			avg_code_q    <= '0;
			dur_code_q    <= '0;
			avg_left_q    <= '0;
			sum_q         <= '0;
			result_q      <= '0;
			per_q         <= '0;
			fail_q        <= 1'b0;
			sysref_prev_q <= 1'b0;
		end
		else
		begin
			state_q       <= state_d;
			avg_code_q    <= avg_code_d;
			dur_code_q    <= dur_code_d;
			avg_left_q    <= avg_left_d;
			sum_q         <= sum_d;
			result_q      <= result_d;
			per_q         <= per_d;
			fail_q        <= fail_d;
			sysref_prev_q <= sysref_in;
		end
	end

	scc_accum #(
		.LEN_W (9)
	) u_accum (
		.mclk_in   (mclk_in),
		.reset_in  (reset_in),
		.start_in  (acc_start),
		.len_in    (scc_count_of(dur_code_q)),
		.sample_in (sysref_sample_in),
		.busy_out  (acc_busy),
		.done_out  (acc_done),
		.ones_out  (acc_ones)
	);

	assign cal_done_flag_out         = trig_q && (state_q == ST_DONE);
	assign computed_delay_result_out = result_q;
	assign cal_busy_out              = (state_q == ST_WAIT) || (state_q == ST_ACC) || acc_busy;
	assign irq_out                   = |(irq_stat_q & irq_en_q);

endmodule

// ---- inc/scc_pkg.sv ----
// Constants for the SYSREF calibration configuration block.
// Assumes a 32-bit AXI4-Lite register bus, word-indexed registers.
package scc_pkg;

	// ------------------------------------------------------------
	// Register indexes (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [9:0]  IDX_CAL_ENABLE      = 10'h2b0;
	localparam logic [9:0]  IDX_SYSREF_CAL_CFG  = 10'h2b1;
	localparam logic [9:0]  IDX_CAL_STATUS      = 10'h2b2;
	localparam logic [9:0]  IDX_CAL_LIVE        = 10'h2c0;
	localparam logic [9:0]  IDX_IRQ_STATUS      = 10'h2c1;
	localparam logic [9:0]  IDX_IRQ_ENABLE      = 10'h2c2;
	localparam logic [9:0]  IDX_IRQ_CLEAR       = 10'h2c3;
	localparam int          ADDR_W              = 12;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  CFG_RESET           = 8'h05;
	localparam int          CFG_AVG_LSB         = 2;
	localparam int          CFG_DUR_LSB         = 0;
	localparam int          STATUS_DONE_BIT     = 17;
	localparam int          RESULT_W            = 17;
	localparam int          IRQ_DONE_BIT        = 0;
	localparam int          IRQ_FAIL_BIT        = 1;
	localparam int          IRQ_W               = 2;

	// ------------------------------------------------------------
	// Counts in sampling-clock cycles
	// ------------------------------------------------------------
	localparam int          PER_W               = 16;
	localparam logic [15:0] MAX_PERIOD_0        = 16'd85;
	localparam logic [15:0] MAX_PERIOD_1        = 16'd1100;
	localparam logic [15:0] MAX_PERIOD_2        = 16'd5200;
	localparam logic [15:0] MAX_PERIOD_3        = 16'd21580;
	localparam logic [8:0]  BASE_COUNT          = 9'd4;
	localparam int          SUM_W               = 17;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY           = 2'b00;
	localparam logic [1:0]  RESP_SLVERR         = 2'b10;

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'b00001,
		ST_WAIT = 5'b00010,
		ST_ACC  = 5'b00100,
		ST_DONE = 5'b01000,
		ST_FAIL = 5'b10000
	} scc_state_t;

	// Code 0..3 selects 4, 16, 64 or 256
	function automatic logic [8:0] scc_count_of(input logic [1:0] code);
		scc_count_of = 9'(BASE_COUNT << (2 * code));
	endfunction

	function automatic logic [15:0] scc_max_period(input logic [1:0] code);
		case (code)
			2'd0:    scc_max_period = MAX_PERIOD_0;
			2'd1:    scc_max_period = MAX_PERIOD_1;
			2'd2:    scc_max_period = MAX_PERIOD_2;
			default: scc_max_period = MAX_PERIOD_3;
		endcase
	endfunction

endpackage

// ---- verif/scc_assertions.sv ----
// Checker for bus handshakes and calibration status pins.
// Assumes binding into scc_top; sees only its ports.
module scc_assertions
#(
	parameter int RW = scc_pkg::RESULT_W
)
(
	// Clock and reset
	input wire logic          mclk_in,
	input wire logic          reset_in,
	// Register bus
	input wire logic          s_axi_awvalid_in,
	input wire logic          s_axi_awready_out,
	input wire logic          s_axi_wvalid_in,
	input wire logic          s_axi_wready_out,
	input wire logic          s_axi_bvalid_out,
	input wire logic          s_axi_arvalid_in,
	input wire logic          s_axi_arready_out,
	input wire logic [31:0]   s_axi_rdata_out,
	input wire logic          s_axi_rvalid_out,
	input wire logic          s_axi_rready_in,
	// Status
	input wire logic          cal_done_flag_out,
	input wire logic [RW-1:0] computed_delay_result_out,
	input wire logic          cal_busy_out
);
	import scc_pkg::*;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	sequence seq_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence seq_rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	AST_B_AFTER_WR: assert property (seq_wr_taken |-> ##[1:2] s_axi_bvalid_out)
		else $error("write response missing");
	AST_R_AFTER_RD: assert property (seq_rd_taken |=> s_axi_rvalid_out)
		else $error("read response missing");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer dropped");
	AST_NO_AW_IN_B: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during response");
	AST_NO_AR_IN_R: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken during response");
	AST_DONE_IDLE: assert property (cal_done_flag_out |-> !cal_busy_out)
		else $error("done while running");
	AST_RESULT_HOLD: assert property (cal_done_flag_out && $past(cal_done_flag_out)
		|-> $stable(computed_delay_result_out))
		else $error("result moved while done");
	AST_START_BY_WRITE: assert property ($rose(cal_busy_out) |-> s_axi_bvalid_out
		|| $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
		else $error("run began without a write");
endmodule
bind scc_top scc_assertions chk_u (.*);

// ---- verif/scc_sysref_src.sv ----
// Clock generator model: periodic one-cycle SYSREF and detector samples.
// Assumes period_in and mode_in change only between calibration runs.
module scc_sysref_src
(
	// Clock and settings
	input  wire logic        mclk_in,
	input  wire logic [15:0] period_in,
	input  wire logic [1:0]  mode_in,
	// Toward the block
	output logic             sysref_out,
	output logic             sample_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_q = 16'h0000;
	initial sysref_out = 1'b0;
	initial sample_out = 1'b0;
	// Mode 0 all low, 1 all high, 2 toggling
	always @(posedge mclk_in)
	begin
		cnt_q <= (cnt_q >= period_in - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
		sysref_out <= (cnt_q == 16'h0000);
		sample_out <= (mode_in == 2'h2) ? !sample_out : mode_in[0];
	end
endmodule

// ---- verif/test_scc_top.sv ----
// Testbench: register tests and calibration runs against the SYSREF model.
// Assumes scc_top, scc_sysref_src and the checker are compiled before it.
module test_scc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scc_pkg::*;
	logic mclk_in = 1'b0, reset_in = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, sysref_in, sysref_sample_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp, mode_q = 2'h0;
	logic cal_done_flag_out, cal_busy_out, irq_out;
	logic [RESULT_W-1:0] computed_delay_result_out;
	logic [15:0] per_q = 16'h003c;
	logic [31:0] rv;
	logic [1:0] md [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
	logic [16:0] res [4] = '{17'h1ffff, 17'h10000, 17'h00000, 17'h10000};
	int n_mismatch = 0, n_compared = 0, cyc;

	scc_top dut_u (.*);
	scc_sysref_src src_u (.mclk_in, .period_in(per_q), .mode_in(mode_q),
		.sysref_out(sysref_in), .sample_out(sysref_sample_in));

	initial forever #2.5 mclk_in = ~mclk_in;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_in(input string nm, input int lo, input int hi, input int g);
		n_compared++;
		if (g < lo || g > hi)
		begin
			n_mismatch++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
		logic a, w, b;
		s_axi_awaddr_in <= {idx, 2'b00};
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do
		begin
			@(negedge mclk_in);
			a = s_axi_awready_out;
			w = s_axi_wready_out;
			b = s_axi_bvalid_out;
			r = s_axi_bresp_out;
			@(posedge mclk_in);
			if (a === 1'b1) s_axi_awvalid_in <= 1'b0;
			if (w === 1'b1) s_axi_wvalid_in <= 1'b0;
		end while (b !== 1'b1);
		s_axi_bready_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic a, v, h;
		s_axi_araddr_in <= {idx, 2'b00};
		s_axi_arvalid_in <= 1'b1;
		do
		begin
			@(negedge mclk_in);
			a = s_axi_arready_out;
			v = s_axi_rvalid_out;
			h = s_axi_rready_in;
			d = s_axi_rdata_out;
			r = s_axi_rresp_out;
			@(posedge mclk_in);
			if (a === 1'b1) s_axi_arvalid_in <= 1'b0;
			if (v === 1'b1 && h !== 1'b1) s_axi_rready_in <= 1'b1;
		end while (!(v === 1'b1 && h === 1'b1));
		s_axi_rready_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	// Start a run, rewrite config mid-run, count busy cycles
	task automatic run(input logic [7:0] c, input logic [7:0] c2, input logic [15:0] p,
		input logic [1:0] m, output int n);
		per_q <= p;
		mode_q <= m;
		wr(IDX_SYSREF_CAL_CFG, {24'h0, c}, rsp);
		wr(IDX_CAL_ENABLE, 32'h0, rsp);
		wr(IDX_CAL_ENABLE, 32'h1, rsp);
		wr(IDX_SYSREF_CAL_CFG, {24'h0, c2}, rsp);
		n = 0;
		@(negedge mclk_in);
		chk("busy", 32'h1, 32'(cal_busy_out));
		while (cal_busy_out === 1'b1)
		begin
			@(negedge mclk_in);
			n++;
		end
		@(posedge mclk_in);
	endtask
	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#300000;
		n_mismatch++;
		close_out;
	end

	initial
	begin
		repeat (16) @(posedge mclk_in);
		reset_in <= 1'b0;
		@(posedge mclk_in);
		rd(IDX_SYSREF_CAL_CFG, rv, rsp);
		chk("cfg reset", 32'h5, rv);
		rd(IDX_CAL_ENABLE, rv, rsp);
		chk("trigger reset", 32'h0, rv);
		rd(IDX_IRQ_ENABLE, rv, rsp);
		chk("irq enable reset", 32'h0, rv);
		rd(10'h2b9, rv, rsp);
		chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
		wr(10'h2b9, 32'h1, rsp);
		chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
		wr(IDX_CAL_STATUS, 32'h1, rsp);
		chk("read-only write", 32'(RESP_OKAY), 32'(rsp));
		wr(IDX_SYSREF_CAL_CFG, 32'hf6, rsp);
		s_axi_wstrb_in <= 4'h0;
		wr(IDX_SYSREF_CAL_CFG, 32'h0, rsp);
		s_axi_wstrb_in <= 4'hf;
		rd(IDX_SYSREF_CAL_CFG, rv, rsp);
		chk("cfg readback", 32'hf6, rv);
		wr(IDX_IRQ_ENABLE, 32'h3, rsp);
		for (int k = 0; k < 4; k++)
		begin
			run({4'h0, 2'(k), 2'h0}, (k == 2) ? 8'h00 : {4'h0, 2'(k), 2'h0}, 16'd60, md[k], cyc);
			chk_in("run cycles", ((4 << 2 * k) - 1) * 60, (4 << 2 * k) * 60 + 80, cyc);
			rd(IDX_CAL_STATUS, rv, rsp);
			chk("status", {14'h0, 1'b1, res[k]}, rv);
			@(negedge mclk_in);
			chk("done pin", 32'h1, 32'(cal_done_flag_out));
			chk("result pin", {15'h0, res[k]}, 32'(computed_delay_result_out));
			chk("irq on done", 32'h1, 32'(irq_out));
			@(posedge mclk_in);
			wr(IDX_IRQ_CLEAR, 32'h1, rsp);
			@(negedge mclk_in);
			chk("irq after clear", 32'h0, 32'(irq_out));
			@(posedge mclk_in);
		end
		wr(IDX_CAL_ENABLE, 32'h0, rsp);
		rd(IDX_CAL_STATUS, rv, rsp);
		chk("done after abort", 32'h0, 32'(rv[17]));
		run(8'h00, 8'h00, 16'd100, 2'h2, cyc);
		rd(IDX_CAL_LIVE, rv, rsp);
		chk("short window fails", 32'h2, rv);
		wr(IDX_IRQ_ENABLE, 32'h1, rsp);
		@(negedge mclk_in);
		chk("irq masked", 32'h0, 32'(irq_out));
		@(posedge mclk_in);
		rd(IDX_IRQ_STATUS, rv, rsp);
		chk("irq status", 32'h2, rv);
		wr(IDX_IRQ_CLEAR, 32'h2, rsp);
		rd(IDX_IRQ_STATUS, rv, rsp);
		chk("irq cleared", 32'h0, rv);
		run(8'h01, 8'h01, 16'd100, 2'h1, cyc);
		rd(IDX_CAL_STATUS, rv, rsp);
		chk("wide window passes", 32'h3ffff, rv);
		close_out;
	end
endmodule
